// ### awce_defs.svh
// constants for the ata write command engine
// Behaviour
// - opcode 3Dh acts as 48-bit DMA write, media commit before ending status
// - queued write 61h with FUA commits to media before completion
// - queued write count in features pair, tag in sector count, zero means 65,536
// - block write C5h raises BSY within 400ns of acceptance
// - block sectors move without interrupts, DRQ qualified only at block start
// - non-multiple count gives whole blocks then one partial block
// - block write aborted when multiple mode is unset or disabled
// - block write error posted after block, ends at failing sector, no more blocks
// - failed block write leaves failing address and residual count in registers
// - interrupt raised when DRQ sets at each block or partial block start after the first
// - only block size of one sector supported and advertised
// - 39h uses 48-bit LBA and 16-bit count, errors like 28-bit block write
// - high byte read via HOB bit; any task file access clears HOB
// - failed 48-bit block write reports 48-bit address, 16-bit residual
// - CEh acts as 48-bit block write with media commit before status
// - sector write 30h writes 1 to 256 sectors, zero means 256
// - sector write sets BSY, then DRQ without first interrupt
// - between sectors BSY set, DRQ clear; next ready clears BSY, sets DRQ, interrupts
// - after last sector BSY held until done, then completion interrupt
// - sector write error stops at failing sector and leaves its address
// - 34h accepts 1 to 65,536 sectors, interrupts per block, 48-bit error address
// - block commands disabled after power-up until multiple mode set nonzero
`ifndef AWCE_DEFS_SVH
`define AWCE_DEFS_SVH
`define AWCE_OP_WR_SECT 8'h30
`define AWCE_OP_WR_SECT_EXT 8'h34
`define AWCE_OP_WR_DMA_EXT 8'h35
`define AWCE_OP_WR_MULT_EXT 8'h39
`define AWCE_OP_WR_DMA_FUA 8'h3D
`define AWCE_OP_WR_QUEUED 8'h61
`define AWCE_OP_WR_MULT 8'hC5
`define AWCE_OP_WR_MULT_FUA 8'hCE
`define AWCE_OP_SET_MULT 8'hC6
`define AWCE_TF_DATA 3'h0
`define AWCE_TF_FEAT 3'h1
`define AWCE_TF_SCNT 3'h2
`define AWCE_TF_LBAL 3'h3
`define AWCE_TF_LBAM 3'h4
`define AWCE_TF_LBAH 3'h5
`define AWCE_TF_DEV 3'h6
`define AWCE_TF_CMD 3'h7
`define AWCE_DEV_FUA_BIT 7
`define AWCE_DEV_LBA_BIT 6
`define AWCE_ST_ERR_BIT 0
`define AWCE_ST_DRQ_BIT 3
`define AWCE_ST_DRDY_BIT 6
`define AWCE_ST_BSY_BIT 7
`define AWCE_ERR_ABRT 8'h04
`define AWCE_ERR_WRITE 8'h40
`define AWCE_MAX_BLOCK 8'h01
`define AWCE_BSY_MAX_NS 400
`define AWCE_CLK_NS 10
`define AWCE_BSY_MAX_CYC ((`AWCE_BSY_MAX_NS) / (`AWCE_CLK_NS))
`define AWCE_WORDS_PER_SECT 256
`endif

// ### awce_pkg.sv
// types for the ata write command engine
package awce_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } awce_tf_req_t;
  typedef struct packed {
    logic [47:0] lba;
    logic [15:0] count;
    logic err;
  } awce_media_rsp_t;
  typedef struct packed {
    logic [47:0] lba;
    logic fua;
    logic queued;
    logic [4:0] tag;
  } awce_media_req_t;
  typedef enum logic [5:0] {
    AWCE_IDLE = 6'h01,
    AWCE_SETUP = 6'h02,
    AWCE_XFER = 6'h04,
    AWCE_PROG = 6'h08,
    AWCE_DONE = 6'h10,
    AWCE_ABORT = 6'h20
  } awce_state_t;
endpackage

// ### awce_fifo.sv
// data buffer between host words and media
`timescale 1ns/100ps
`default_nettype none
module awce_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("depth must be a power of two of at least 2");
    end
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;
  wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  wire empty = (wp_ff == rp_ff);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_ff[rp_ff[AW-1:0]];
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ### awce_engine.sv
// ata write command engine: task file, sequencing, buffered data path
`timescale 1ns/100ps
`default_nettype none
`include "awce_defs.svh"
module awce_engine #(
  parameter int FIFO_DEPTH = 8,
  parameter int WORDS_PER_SECT = `AWCE_WORDS_PER_SECT
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire awce_pkg::awce_tf_req_t tf_req_i,
  output logic [15:0] tf_rdata_o,
  input wire logic hob_i,
  output logic hob_clr_o,
  output logic intrq_o,
  output logic [7:0] status_o,
  output logic [7:0] error_o,
  output logic [7:0] mult_size_o,
  input wire logic write_cache_en_i,
  output awce_pkg::awce_media_req_t media_req_o,
  output logic media_valid_o,
  output logic [15:0] media_data_o,
  input wire logic media_ready_i,
  output logic media_commit_o,
  output logic media_sect_end_o,
  input wire logic media_done_i,
  input wire logic media_err_i,
  output logic dma_mode_o
);
  import awce_pkg::*;
  initial begin
    if (WORDS_PER_SECT < 2 || FIFO_DEPTH < 2) begin
      $error("unsupported sector or fifo size");
    end
  end
  // ==========================================================
  // task file registers, 16 bits each except device, error and block size at 8 bits
  logic [15:0] feat_ff, scnt_ff, lbal_ff, lbam_ff, lbah_ff;
  logic [7:0] dev_ff, err_ff, mult_ff;
  logic bsy_ff, drq_ff, errb_ff, intrq_ff;
  logic [15:0] remain_ff;
  logic [16:0] left_ff;
  logic [47:0] cur_lba_ff;
  logic [15:0] wcnt_ff;
  logic fua_ff, queued_ff, ext_ff, multi_ff, dma_ff, wr_err_ff;
  logic [4:0] tag_ff;
  awce_state_t state_ff;
  awce_state_t nxt_state;

  // the hob input is the device-control bit; host drives it on the same clock
  wire tf_wr = tf_req_i.wr && state_ff == AWCE_IDLE;
  wire data_wr = tf_req_i.wr && tf_req_i.addr == `AWCE_TF_DATA;
  wire cmd_wr = tf_wr && tf_req_i.addr == `AWCE_TF_CMD;
  wire [7:0] opc = tf_req_i.wdata[7:0];
  assign hob_clr_o = tf_req_i.wr || tf_req_i.rd;

  function automatic logic [15:0] shift_in(input logic [15:0] old, input logic [7:0] b);
    shift_in = {old[7:0], b};
  endfunction
  function automatic logic [7:0] hi_lo(input logic [15:0] v, input logic hob);
    hi_lo = hob ? v[15:8] : v[7:0];
  endfunction

  // ==========================================================
  // command decode
  wire op_sect = opc == `AWCE_OP_WR_SECT;
  wire op_sect_ext = opc == `AWCE_OP_WR_SECT_EXT;
  wire op_mult = opc == `AWCE_OP_WR_MULT;
  wire op_mult_ext = opc == `AWCE_OP_WR_MULT_EXT || opc == `AWCE_OP_WR_MULT_FUA;
  wire op_dma = opc == `AWCE_OP_WR_DMA_EXT || opc == `AWCE_OP_WR_DMA_FUA;
  wire op_q = opc == `AWCE_OP_WR_QUEUED;
  wire op_setm = opc == `AWCE_OP_SET_MULT;
  wire op_known = op_sect | op_sect_ext | op_mult | op_mult_ext | op_dma | op_q;
  wire is_multi = op_mult | op_mult_ext;
  wire is_ext = op_sect_ext | op_mult_ext | op_dma | op_q;
  wire mult_ok = mult_ff != 8'h00;
  wire cmd_abort = cmd_wr && ((is_multi && !mult_ok) || !(op_known || op_setm));
  wire cmd_go = cmd_wr && op_known && !(is_multi && !mult_ok);
  wire op_fua = opc == `AWCE_OP_WR_DMA_FUA || opc == `AWCE_OP_WR_MULT_FUA
    || (op_q && dev_ff[`AWCE_DEV_FUA_BIT]);
  wire [15:0] cnt_src = op_q ? feat_ff : scnt_ff;
  wire [16:0] cnt_ext = (cnt_src == 16'h0000) ? 17'h10000 : {1'b0, cnt_src};
  wire [16:0] cnt_28 = (scnt_ff[7:0] == 8'h00) ? 17'h00100 : {9'h000, scnt_ff[7:0]};
  wire [16:0] cnt_start = is_ext ? cnt_ext : cnt_28;
  wire [47:0] lba_start = is_ext ? {lbah_ff[15:8], lbam_ff[15:8], lbal_ff[15:8],
    lbah_ff[7:0], lbam_ff[7:0], lbal_ff[7:0]}
    : {20'h00000, dev_ff[3:0], lbah_ff[7:0], lbam_ff[7:0], lbal_ff[7:0]};
  // block size limited to one sector, so every sector starts a block
  wire [16:0] blk = {9'h000, mult_ff};

  // ==========================================================
  // data path through buffer
  logic fifo_in_ready;
  // dma and queued data go through the data port with DRQ low, only while the transfer state is open
  wire in_valid = data_wr && !bsy_ff && (drq_ff || (dma_ff && state_ff == AWCE_XFER));
  awce_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(tf_req_i.wdata),
    .out_valid_o(media_valid_o),
    .out_ready_i(media_ready_i),
    .out_data_o(media_data_o)
  );
  wire word_in = in_valid && fifo_in_ready;
  wire last_word = wcnt_ff == 16'(WORDS_PER_SECT - 1);
  wire sect_done = word_in && last_word;
  // one-sector blocks: whole blocks always fit, the partial block is empty
  wire last_sect = left_ff == 17'h00001;

  // ==========================================================
  // sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      AWCE_IDLE: begin
        if (cmd_abort) begin
          nxt_state = AWCE_ABORT;
        end else if (cmd_go) begin
          nxt_state = AWCE_SETUP;
        end else if (cmd_wr && op_setm) begin
          // block size load completes at once, so BSY does not stay set
          nxt_state = AWCE_DONE;
        end
      end
      AWCE_SETUP: nxt_state = AWCE_XFER;
      AWCE_XFER: begin
        if (sect_done) begin
          nxt_state = AWCE_PROG;
        end
      end
      AWCE_PROG: begin
        if (media_err_i) begin
          nxt_state = AWCE_ABORT;
        end else if (media_done_i && last_sect) begin
          nxt_state = AWCE_DONE;
        end else if (media_done_i) begin
          nxt_state = AWCE_XFER;
        end
      end
      AWCE_DONE: nxt_state = AWCE_IDLE;
      AWCE_ABORT: nxt_state = AWCE_IDLE;
      default: nxt_state = AWCE_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= AWCE_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bsy_ff <= 1'b0;
      drq_ff <= 1'b0;
      errb_ff <= 1'b0;
      intrq_ff <= 1'b0;
      err_ff <= 8'h00;
      wr_err_ff <= 1'b0;
    end else begin
      if (tf_req_i.rd && tf_req_i.addr == `AWCE_TF_CMD) begin
        intrq_ff <= 1'b0;
      end
      case (state_ff)
        AWCE_IDLE: begin
          if (cmd_wr) begin
            bsy_ff <= 1'b1;
            errb_ff <= 1'b0;
            err_ff <= 8'h00;
            wr_err_ff <= 1'b0;
            intrq_ff <= 1'b0;
          end
        end
        AWCE_SETUP: begin
          bsy_ff <= 1'b0;
          drq_ff <= !dma_ff;
        end
        AWCE_XFER: begin
          if (sect_done) begin
            bsy_ff <= 1'b1;
            drq_ff <= 1'b0;
          end
        end
        AWCE_PROG: begin
          if (media_err_i) begin
            wr_err_ff <= 1'b1;
          end else if (media_done_i && !last_sect) begin
            bsy_ff <= 1'b0;
            drq_ff <= !dma_ff;
            intrq_ff <= !dma_ff;
          end
        end
        AWCE_DONE: begin
          bsy_ff <= 1'b0;
          intrq_ff <= 1'b1;
        end
        AWCE_ABORT: begin
          bsy_ff <= 1'b0;
          drq_ff <= 1'b0;
          errb_ff <= 1'b1;
          err_ff <= wr_err_ff ? (`AWCE_ERR_WRITE | `AWCE_ERR_ABRT) : `AWCE_ERR_ABRT;
          intrq_ff <= 1'b1;
        end
        default: bsy_ff <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // command context and progress
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      feat_ff <= 16'h0000;
      scnt_ff <= 16'h0000;
      lbal_ff <= 16'h0000;
      lbam_ff <= 16'h0000;
      lbah_ff <= 16'h0000;
      dev_ff <= 8'h00;
      mult_ff <= 8'h00;
      left_ff <= 17'h00000;
      remain_ff <= 16'h0000;
      cur_lba_ff <= 48'h000000000000;
      wcnt_ff <= 16'h0000;
      fua_ff <= 1'b0;
      queued_ff <= 1'b0;
      ext_ff <= 1'b0;
      multi_ff <= 1'b0;
      dma_ff <= 1'b0;
      tag_ff <= 5'h00;
    end else begin
      if (tf_wr) begin
        case (tf_req_i.addr)
          `AWCE_TF_FEAT: feat_ff <= shift_in(feat_ff, tf_req_i.wdata[7:0]);
          `AWCE_TF_SCNT: scnt_ff <= shift_in(scnt_ff, tf_req_i.wdata[7:0]);
          `AWCE_TF_LBAL: lbal_ff <= shift_in(lbal_ff, tf_req_i.wdata[7:0]);
          `AWCE_TF_LBAM: lbam_ff <= shift_in(lbam_ff, tf_req_i.wdata[7:0]);
          `AWCE_TF_LBAH: lbah_ff <= shift_in(lbah_ff, tf_req_i.wdata[7:0]);
          `AWCE_TF_DEV: dev_ff <= tf_req_i.wdata[7:0];
          default: dev_ff <= dev_ff;
        endcase
      end
      if (cmd_wr && op_setm) begin
        mult_ff <= (scnt_ff[7:0] <= `AWCE_MAX_BLOCK) ? scnt_ff[7:0] : 8'h00;
      end
      if (cmd_go) begin
        left_ff <= cnt_start;
        cur_lba_ff <= lba_start;
        fua_ff <= op_fua;
        queued_ff <= op_q;
        ext_ff <= is_ext;
        multi_ff <= is_multi;
        dma_ff <= op_dma | op_q;
        tag_ff <= scnt_ff[7:3];
        wcnt_ff <= 16'h0000;
      end
      if (word_in) begin
        wcnt_ff <= last_word ? 16'h0000 : wcnt_ff + 16'h0001;
      end
      if (state_ff == AWCE_PROG && media_done_i && !media_err_i) begin
        left_ff <= left_ff - 17'h00001;
        cur_lba_ff <= cur_lba_ff + 48'h000000000001;
      end
      if (state_ff == AWCE_PROG && media_err_i) begin
        // failing sector address and outstanding count back into the registers
        remain_ff <= left_ff[15:0];
        scnt_ff <= left_ff[15:0];
        lbal_ff <= {cur_lba_ff[31:24], cur_lba_ff[7:0]};
        lbam_ff <= {cur_lba_ff[39:32], cur_lba_ff[15:8]};
        lbah_ff <= {cur_lba_ff[47:40], cur_lba_ff[23:16]};
        if (!ext_ff) begin
          dev_ff <= {dev_ff[7:4], cur_lba_ff[27:24]};
        end
      end
    end
  end

  // ==========================================================
  // outputs
  wire [7:0] rd_byte =
    (tf_req_i.addr == `AWCE_TF_FEAT) ? err_ff :
    (tf_req_i.addr == `AWCE_TF_SCNT) ? hi_lo(scnt_ff, hob_i) :
    (tf_req_i.addr == `AWCE_TF_LBAL) ? hi_lo(lbal_ff, hob_i) :
    (tf_req_i.addr == `AWCE_TF_LBAM) ? hi_lo(lbam_ff, hob_i) :
    (tf_req_i.addr == `AWCE_TF_LBAH) ? hi_lo(lbah_ff, hob_i) :
    (tf_req_i.addr == `AWCE_TF_DEV) ? dev_ff : status_o;
  logic [15:0] rdata_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 16'h0000;
    end else if (tf_req_i.rd) begin
      rdata_ff <= {8'h00, rd_byte};
    end
  end
  assign tf_rdata_o = rdata_ff;
  assign status_o = {bsy_ff, !bsy_ff, 2'b00, drq_ff, 2'b00, errb_ff};
  assign error_o = err_ff;
  assign intrq_o = intrq_ff;
  assign mult_size_o = `AWCE_MAX_BLOCK;
  assign dma_mode_o = dma_ff;
  assign media_req_o = '{lba: cur_lba_ff, fua: fua_ff, queued: queued_ff, tag: tag_ff};
  // media holds done until data is durable when forced commit applies
  assign media_commit_o = fua_ff | !write_cache_en_i;
  assign media_sect_end_o = state_ff == AWCE_PROG;
endmodule
`default_nettype wire

// ### awce_monitor.sv
// checker bound to the write command engine ports
`timescale 1ns/100ps
`default_nettype none
module awce_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire awce_pkg::awce_tf_req_t tf_req_i,
  input wire logic hob_clr_o,
  input wire logic intrq_o,
  input wire logic [7:0] status_o,
  input wire logic [7:0] error_o,
  input wire logic [7:0] mult_size_o,
  input wire logic media_sect_end_o,
  input wire logic media_done_i,
  input wire logic media_err_i,
  input wire logic dma_mode_o
);
  import awce_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // decode
  wire idle = !status_o[7] && !status_o[3];
  wire cmd = tf_req_i.wr && tf_req_i.addr == 3'h7 && idle;
  wire pio_end = media_sect_end_o && !dma_mode_o;
  // ==========
  // properties
  sect_start_a: assert property (
    cmd && tf_req_i.wdata[7:0] == 8'h30 |=> status_o[7] ##1 (status_o[3] && !status_o[7] && !intrq_o))
    else $error("sector write start order wrong");
  mult_busy_a: assert property (
    cmd && tf_req_i.wdata[7:0] == 8'hC5 |-> ##[1:40] (status_o[7] || status_o[0]))
    else $error("block write busy late");
  hob_clear_a: assert property (hob_clr_o == (tf_req_i.wr || tf_req_i.rd))
    else $error("high byte clear mismatch");
  block_size_a: assert property (mult_size_o == 8'h01)
    else $error("advertised block size wrong");
  media_wait_a: assert property (pio_end |-> status_o[7] && !status_o[3])
    else $error("flags wrong while sector pending");
  next_sector_a: assert property (
    pio_end && media_done_i && !media_err_i |=> (status_o[3] && !status_o[7] && intrq_o)
    or (status_o[7] ##1 (idle && intrq_o)))
    else $error("no next block or completion");
  media_fault_a: assert property (
    media_sect_end_o && media_err_i |-> ##[1:3] (status_o[0] && error_o == 8'h44 && intrq_o && idle))
    else $error("fault not reported");
  error_flag_a: assert property ((error_o != 8'h00) == status_o[0])
    else $error("error flag and code disagree");
endmodule
bind awce_engine awce_monitor u_awce_monitor (
  .clk_i(clk_i), .resetn_i(resetn_i), .tf_req_i(tf_req_i), .hob_clr_o(hob_clr_o),
  .intrq_o(intrq_o), .status_o(status_o), .error_o(error_o), .mult_size_o(mult_size_o),
  .media_sect_end_o(media_sect_end_o), .media_done_i(media_done_i),
  .media_err_i(media_err_i), .dma_mode_o(dma_mode_o)
);
`default_nettype wire

// ### awce_media_model.sv
// media side model: stalls, result latency, injected fault
`timescale 1ns/100ps
`default_nettype none
module awce_media_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sect_end_i,
  input wire logic stall_i,
  input wire logic fail_i,
  input wire logic [3:0] lat_i,
  output logic ready_o,
  output logic done_o,
  output logic err_o
);
  logic [3:0] wait_ff;
  logic [1:0] tick_ff;
  logic busy_ff;
  assign ready_o = !(stall_i && tick_ff != 2'h0);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_ff <= 4'h0;
      tick_ff <= 2'h0;
      busy_ff <= 1'b0;
      done_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      tick_ff <= tick_ff + 2'h1;
      done_o <= 1'b0;
      err_o <= 1'b0;
      if (!sect_end_i) begin
        busy_ff <= 1'b0;
        wait_ff <= 4'h0;
      end else if (!busy_ff) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff == lat_i) begin
          busy_ff <= 1'b1;
          done_o <= !fail_i;
          err_o <= fail_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// testbench for the write command engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import awce_pkg::*;
  localparam int WPS = 4;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  awce_tf_req_t tf_req_i = '0;
  logic hob_i = 1'b0;
  logic stall = 1'b1;
  logic fail = 1'b0;
  logic [3:0] lat = 4'h6;
  logic commit_seen = 1'b0;
  logic hob_clr_o, intrq_o, ready, done, err, sect_end, commit, mvalid, dma;
  logic [7:0] status_o, error_o, mult_o;
  logic [15:0] tf_rdata_o, mdata;
  awce_media_req_t mreq;
  logic [15:0] rx[$];
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] ops[3] = '{8'h3D, 8'h61, 8'hCE};
  always #5 clk_i = ~clk_i;
  awce_engine #(.FIFO_DEPTH(8), .WORDS_PER_SECT(WPS)) u_awce_engine (
    .clk_i(clk_i), .resetn_i(resetn_i), .tf_req_i(tf_req_i), .tf_rdata_o(tf_rdata_o),
    .hob_i(hob_i), .hob_clr_o(hob_clr_o), .intrq_o(intrq_o), .status_o(status_o),
    .error_o(error_o), .mult_size_o(mult_o), .write_cache_en_i(1'b1), .media_req_o(mreq),
    .media_valid_o(mvalid), .media_data_o(mdata), .media_ready_i(ready), .media_commit_o(commit),
    .media_sect_end_o(sect_end), .media_done_i(done), .media_err_i(err), .dma_mode_o(dma));
  awce_media_model u_awce_media_model (
    .clk_i(clk_i), .resetn_i(resetn_i), .sect_end_i(sect_end), .stall_i(stall),
    .fail_i(fail), .lat_i(lat), .ready_o(ready), .done_o(done), .err_o(err));
  // ==========
  // collector and timeout
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (mvalid && ready) rx.push_back(mdata);
    if (sect_end) commit_seen <= commit;
    if (hob_clr_o) hob_i <= 1'b0;
    if (cyc == 30000) begin
      n_errors++;
      complete_run();
    end
  end
  // ==========
  // tasks
  task complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic tf(input logic [2:0] a, input logic wr, input logic [15:0] d);
    step(1);
    tf_req_i = '{a, wr, !wr, d};
    step(1);
    tf_req_i = '0;
  endtask
  task automatic wait_st(input int b, input logic v);
    int i;
    for (i = 0; i < 600 && status_o[b] !== v; i++) step(1);
    check(status_o[b], v);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] ft, input logic [15:0] cnt,
      input logic [47:0] lba);
    int k;
    tf(3'h1, 1'b1, {8'h00, ft[15:8]});
    tf(3'h1, 1'b1, {8'h00, ft[7:0]});
    tf(3'h2, 1'b1, {8'h00, cnt[15:8]});
    tf(3'h2, 1'b1, {8'h00, cnt[7:0]});
    for (k = 0; k < 3; k++) begin
      tf(3'h3 + k[2:0], 1'b1, {8'h00, lba[24+8*k +: 8]});
      tf(3'h3 + k[2:0], 1'b1, {8'h00, lba[8*k +: 8]});
    end
    tf(3'h6, 1'b1, 16'h00E0);
    tf(3'h7, 1'b1, {8'h00, op});
  endtask
  task automatic xfer(input int n, input int bad);
    int i;
    int j;
    fail = 1'b0;
    for (i = 1; i <= n && !fail; i++) begin
      wait_st(3, 1'b1);
      if (i > 1) check(intrq_o, 1'b1);
      tf(3'h7, 1'b0, 16'h0000);
      fail = (i == bad);
      for (j = 0; j < WPS; j++) tf(3'h0, 1'b1, 16'(i * 16 + j));
      wait_st(7, 1'b1);
      check(status_o[3], 1'b0);
    end
    wait_st(7, 1'b0);
    check(intrq_o, 1'b1);
    check(48'(rx.size()), 48'((i - 1) * WPS));
    for (i = 1; rx.size() > 0; i++) check(rx.pop_front(), 16'((i - 1) / WPS * 16 + 16 + (i - 1) % WPS));
    fail = 1'b0;
  endtask
  task automatic read_back(input logic [15:0] cnt, input logic [47:0] lba);
    int k;
    tf(3'h2, 1'b0, 16'h0000);
    check(tf_rdata_o, cnt[7:0]);
    hob_i = 1'b1;
    tf(3'h2, 1'b0, 16'h0000);
    check(tf_rdata_o, cnt[15:8]);
    for (k = 0; k < 3; k++) begin
      tf(3'h3 + k[2:0], 1'b0, 16'h0000);
      check(tf_rdata_o, lba[8*k +: 8]);
      hob_i = 1'b1;
      tf(3'h3 + k[2:0], 1'b0, 16'h0000);
      check(tf_rdata_o, lba[24+8*k +: 8]);
    end
  endtask
  // ==========
  // tests
  initial begin
    int k;
    step(10);
    resetn_i = 1'b1;
    check(status_o, 8'h40);
    check(mult_o, 8'h01);
    cmd(8'hC5, 16'h0000, 16'h0001, 48'h0);
    step(3);
    check(error_o, 8'h04);
    check(intrq_o, 1'b1);
    tf(3'h7, 1'b0, 16'h0000);
    cmd(8'h30, 16'h0000, 16'h0002, 48'h123456);
    xfer(2, 0);
    check(error_o, 8'h00);
    cmd(8'hC6, 16'h0000, 16'h0001, 48'h0);
    step(4);
    check(status_o[7], 1'b0);
    cmd(8'hC5, 16'h0000, 16'h0003, 48'h000010);
    xfer(3, 2);
    check(error_o, 8'h44);
    read_back(16'h0002, 48'h000011);
    cmd(8'h39, 16'h0000, 16'h0002, 48'h33221100FFFF);
    xfer(2, 2);
    read_back(16'h0001, 48'h332211010000);
    stall = 1'b0;
    lat = 4'h0;
    cmd(8'h34, 16'h0000, 16'h0001, 48'h0);
    xfer(1, 0);
    cmd(8'h30, 16'h0000, 16'h0000, 48'h0);
    xfer(256, 0);
    lat = 4'h8;
    for (k = 0; k < 3; k++) begin
      commit_seen = 1'b0;
      cmd(ops[k], 16'h0001, ops[k] == 8'h61 ? 16'h0028 : 16'h0001, 48'h0);
      if (ops[k] == 8'hCE) begin
        xfer(1, 0);
      end else begin
        step(3);
        if (ops[k] == 8'h61) check({mreq.fua, mreq.queued, mreq.tag}, 7'h65);
        for (int j = 0; j < WPS; j++) tf(3'h0, 1'b1, 16'h00A0);
        for (int j = 0; j < 600 && intrq_o !== 1'b1; j++) step(1);
        check(intrq_o, 1'b1);
        rx.delete();
      end
      check(commit_seen, 1'b1);
    end
    complete_run();
  end
endmodule
`default_nettype wire
